// [core/hrxb_pkg.sv]
package hrxb_pkg;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CMP    = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_CRCERR = 12'h00c;
  localparam logic [11:0] ADDR_SYNC   = 12'h010;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_ASEL  = 1;
  localparam int CTRL_ACE   = 2;
  localparam int CTRL_ROCE  = 3;
  localparam int CTRL_TRANS = 4;
  localparam int CTRL_BUS16 = 5;
  localparam int CTRL_MODE  = 6;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [1:0] MODE_MODEM = 2'h0;
  localparam logic [3:0] STUFF_ONES = 4'h5;
  localparam logic [3:0] FLAG_ONES  = 4'h6;
  localparam logic [3:0] IDLE_ONES  = 4'hf;
  localparam logic [2:0] MIN_OCTETS = 3'h4;
  localparam logic [7:0] BCAST_ADDR = 8'hff;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'h8408;
  localparam logic [15:0] CRC_GOOD  = 16'hf0b8;
  localparam logic [1:0] TAG_DATA    = 2'h0;
  localparam logic [1:0] TAG_EOF_OK  = 2'h1;
  localparam logic [1:0] TAG_EOF_BAD = 2'h2;
  typedef enum logic [1:0] {ST_OOF, ST_FLAG, ST_INFRAME} hrxb_state_e;
endpackage

// [core/hrxb_receiver.sv]
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module hrxb_receiver import hrxb_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_link_clk,
  input  wire logic        rx_link_data,
  input  wire logic        carrier_sense_input_n,
  input  wire logic        dma_ack,
  output logic             dma_req,
  output logic      [7:0]  dma_data,
  output logic      [1:0]  dma_tag,
  output logic             dma_ptr_reset,
  output logic             good_frame,
  output logic             crc_error,
  output logic             rx_overrun,
  output logic             rx_idle,
  output logic             carrier_change
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------
  // link synchronisers
  // ----------------------------------------
  logic [2:0] clk_sy;
  logic [1:0] dat_sy;
  logic [2:0] cs_sy;
  logic       bit_stb;
  logic       rbit;
  logic       cs_level_n;
  logic       cs_assert;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      clk_sy <= 3'h0;
      dat_sy <= 2'h0;
      cs_sy  <= 3'h7;
    end else begin
      clk_sy <= {clk_sy[1:0], rx_link_clk};
      dat_sy <= {dat_sy[0], rx_link_data};
      cs_sy  <= {cs_sy[1:0], carrier_sense_input_n};
    end
  end

  assign bit_stb    = clk_sy[1] & ~clk_sy[2];
  assign rbit       = dat_sy[1];
  assign cs_level_n = cs_sy[1];
  assign cs_assert  = cs_sy[2] & ~cs_sy[1];

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0]  ctrl;
  logic [7:0]  cmp0;
  logic [7:0]  cmp1;
  logic [7:0]  wild;
  logic [2:0]  sync_phase;
  logic [15:0] crc_cnt;
  logic [2:0]  residue;
  logic        last_bad;
  logic        crc_inc;
  logic        wr_stb;
  logic        en;
  logic        trans;
  logic [CW-1:0] cnt;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_CMP) || (a == ADDR_STATUS)
          || (a == ADDR_CRCERR) || (a == ADDR_SYNC);
  endfunction

  assign wr_stb = psel & penable & pready & pwrite;
  assign en     = ctrl[CTRL_EN];
  assign trans  = ctrl[CTRL_TRANS];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == ADDR_CTRL) begin
          prdata[7:0] <= ctrl;
        end else if (paddr == ADDR_CMP) begin
          prdata[23:0] <= {wild, cmp1, cmp0};
        end else if (paddr == ADDR_STATUS) begin
          prdata[2:0]     <= residue;
          prdata[3]       <= rx_idle;
          prdata[4]       <= ~cs_level_n;
          prdata[5]       <= last_bad;
          prdata[8 +: CW] <= cnt;
        end else if (paddr == ADDR_CRCERR) begin
          prdata[15:0] <= crc_cnt;
        end else if (paddr == ADDR_SYNC) begin
          prdata[2:0] <= sync_phase;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl       <= CTRL_RESET;
      cmp0       <= 8'h00;
      cmp1       <= 8'h00;
      wild       <= 8'h00;
      sync_phase <= 3'h0;
    end else if (wr_stb) begin
      if (paddr == ADDR_CTRL) begin
        ctrl <= pwdata[7:0];
      end else if (paddr == ADDR_CMP) begin
        {wild, cmp1, cmp0} <= pwdata[23:0];
      end else if (paddr == ADDR_SYNC) begin
        sync_phase <= pwdata[2:0];
      end
    end
  end

  // write clears, a same-cycle error wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      crc_cnt <= 16'h0000;
    end else if (wr_stb && paddr == ADDR_CRCERR) begin
      crc_cnt <= crc_inc ? 16'h0001 : 16'h0000;
    end else if (crc_inc && crc_cnt != 16'hffff) begin
      crc_cnt <= crc_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // ones counter, idle and carrier events
  // ----------------------------------------
  logic [3:0] ones;

  always_ff @(posedge sys_clk) begin
    if (!nrst || !en) begin
      ones    <= 4'h0;
      rx_idle <= 1'b0;
    end else if (bit_stb) begin
      if (!rbit) begin
        ones <= 4'h0;
      end else if (ones != IDLE_ONES) begin
        ones <= ones + 4'h1;
      end
      rx_idle <= rbit && ones >= IDLE_ONES - 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      carrier_change <= 1'b0;
    end else begin
      carrier_change <= cs_sy[1] ^ cs_sy[2];
    end
  end

  // ----------------------------------------
  // bit handler
  // ----------------------------------------
  hrxb_state_e state;
  logic [6:0]  dl;
  logic [2:0]  dn;
  logic [7:0]  asm_b;
  logic [2:0]  acnt;
  logic [15:0] crc;
  logic [2:0]  octets;
  logic [2:0]  lcnt;
  logic        sync_pend;
  logic        push;
  logic [7:0]  push_data;
  logic [1:0]  push_tag;
  logic        flush;
  logic        is_stuff;
  logic        is_flag;
  logic        is_abort;
  logic        emerge;
  logic        ebit;
  logic [7:0]  new_byte;
  logic        chk_now;
  logic        tsync;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a0,
                                    input logic [7:0] a1, input logic [7:0] m);
    addr_hit = (((b ^ a0) & ~m) == 8'h00) || (b == a1) || (b == BCAST_ADDR);
  endfunction

  assign is_stuff = ones == STUFF_ONES && !rbit;
  assign is_flag  = ones == FLAG_ONES && !rbit;
  assign is_abort = ones == FLAG_ONES && rbit;
  assign ebit     = dl[0];
  assign emerge   = state != ST_OOF && !is_stuff && !is_flag && !is_abort && dn == 3'h7;
  assign new_byte = {ebit, asm_b[7:1]};
  assign chk_now  = ctrl[CTRL_ACE] && octets == (ctrl[CTRL_ASEL] ? 3'h0 : 3'h1);
  assign tsync    = (ctrl[CTRL_MODE +: 2] == MODE_MODEM) ? sync_pend : (lcnt == sync_phase);

  always_ff @(posedge sys_clk) begin
    if (!nrst || !en || !trans) begin
      sync_pend <= 1'b0;
      lcnt      <= 3'h0;
    end else begin
      if (bit_stb) begin
        lcnt      <= lcnt + 3'h1;
        sync_pend <= cs_assert;
      end else if (cs_assert) begin
        sync_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst || !en) begin
      state         <= ST_OOF;
      dl            <= 7'h00;
      dn            <= 3'h0;
      asm_b         <= 8'h00;
      acnt          <= 3'h0;
      crc           <= CRC_INIT;
      octets        <= 3'h0;
      push          <= 1'b0;
      push_data     <= 8'h00;
      push_tag      <= TAG_DATA;
      flush         <= !nrst || !en;
      dma_ptr_reset <= 1'b0;
      good_frame    <= 1'b0;
      crc_inc       <= 1'b0;
      residue       <= nrst ? residue : 3'h0;
      last_bad      <= nrst ? last_bad : 1'b0;
    end else begin
      push          <= 1'b0;
      flush         <= 1'b0;
      dma_ptr_reset <= 1'b0;
      good_frame    <= 1'b0;
      crc_inc       <= 1'b0;
      if (bit_stb && trans) begin
        asm_b <= {rbit, asm_b[7:1]};
        if (tsync) begin
          acnt  <= 3'h1;
          state <= ST_INFRAME;
        end else if (state == ST_INFRAME) begin
          acnt <= acnt + 3'h1;
          if (acnt == 3'h7) begin
            push      <= 1'b1;
            push_data <= {rbit, asm_b[7:1]};
            push_tag  <= TAG_DATA;
          end
        end
      end else if (bit_stb) begin
        if (is_flag) begin
          dn     <= 3'h0;
          acnt   <= 3'h0;
          asm_b  <= 8'h00;
          crc    <= CRC_INIT;
          octets <= 3'h0;
          state  <= ST_FLAG;
          if (state == ST_INFRAME) begin
            if (octets < MIN_OCTETS) begin
              flush         <= 1'b1;
              dma_ptr_reset <= 1'b1;
              state         <= ST_OOF;
            end else begin
              residue  <= acnt;
              last_bad <= crc != CRC_GOOD;
              push_data <= asm_b >> (4'h8 - {1'b0, acnt});
              if (crc == CRC_GOOD) begin
                push       <= 1'b1;
                push_tag   <= TAG_EOF_OK;
                good_frame <= 1'b1;
              end else begin
                crc_inc <= 1'b1;
                if (ctrl[CTRL_ROCE]) begin
                  push     <= 1'b1;
                  push_tag <= TAG_EOF_BAD;
                end else begin
                  flush         <= 1'b1;
                  dma_ptr_reset <= 1'b1;
                end
              end
            end
          end
        end else if (is_abort && state != ST_OOF) begin
          state <= ST_OOF;
          if (state == ST_INFRAME) begin
            flush         <= 1'b1;
            dma_ptr_reset <= 1'b1;
          end
        end else if (!is_stuff && state != ST_OOF) begin
          dl <= {rbit, dl[6:1]};
          if (dn != 3'h7) begin
            dn <= dn + 3'h1;
          end
          if (emerge) begin
            state <= ST_INFRAME;
            crc   <= crc_step(crc, ebit);
            asm_b <= new_byte;
            acnt  <= acnt + 3'h1;
            if (acnt == 3'h7) begin
              if (octets != 3'h7) begin
                octets <= octets + 3'h1;
              end
              if (chk_now && !addr_hit(new_byte, cmp0, cmp1, wild)) begin
                flush         <= 1'b1;
                dma_ptr_reset <= 1'b1;
                state         <= ST_OOF;
              end else begin
                push      <= 1'b1;
                push_data <= new_byte;
                push_tag  <= TAG_DATA;
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // receive fifo
  // ----------------------------------------
  logic [9:0]    mem [FIFO_DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic          pop;
  logic          full;
  logic          wr_ok;

  assign pop   = dma_ack && cnt != CW'(0);
  assign full  = cnt == CW'(FIFO_DEPTH);
  assign wr_ok = push && (!full || pop);

  always_ff @(posedge sys_clk) begin
    if (!nrst || flush) begin
      wp         <= '0;
      rp         <= '0;
      cnt        <= '0;
      rx_overrun <= 1'b0;
    end else begin
      rx_overrun <= push && full && !pop;
      if (wr_ok) begin
        wp <= (wp == PW'(FIFO_DEPTH - 1)) ? '0 : wp + PW'(1);
      end
      if (pop) begin
        rp <= (rp == PW'(FIFO_DEPTH - 1)) ? '0 : rp + PW'(1);
      end
      if (wr_ok && !pop) begin
        cnt <= cnt + CW'(1);
      end else if (pop && !wr_ok) begin
        cnt <= cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_ok) begin
      mem[wp] <= {push_tag, push_data};
    end
  end

  // ----------------------------------------
  // dma side outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dma_req   <= 1'b0;
      dma_data  <= 8'h00;
      dma_tag   <= TAG_DATA;
      crc_error <= 1'b0;
    end else begin
      dma_req   <= ctrl[CTRL_BUS16] ? (cnt >= CW'(2)) : (cnt != CW'(0));
      dma_data  <= (cnt != CW'(0)) ? mem[rp][7:0] : 8'h00;
      dma_tag   <= (cnt != CW'(0)) ? mem[rp][9:8] : TAG_DATA;
      crc_error <= crc_inc;
    end
  end

endmodule

// [tb/hrxb_receiver_chk.sv]
`timescale 1ns/1ps
module hrxb_receiver_chk #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_link_data,
  input wire logic        carrier_sense_input_n,
  input wire logic        dma_ptr_reset,
  input wire logic        good_frame,
  input wire logic        crc_error,
  input wire logic        rx_idle,
  input wire logic        carrier_change
);
  // ---------------------------------
  // port relations
  // ---------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_apb_answer: assert property (psel && !penable |=> pready) else $error("no apb answer");
  chk_ready_once: assert property (pready |=> !pready) else $error("pready too long");
  chk_err_empty: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error reply");
  chk_good_clean: assert property (good_frame |-> !crc_error && !dma_ptr_reset) else $error("good with fault");
  chk_good_pulse: assert property (good_frame |=> !good_frame) else $error("good too long");
  chk_crc_pulse: assert property (crc_error |=> !crc_error) else $error("crc too long");
  chk_rewind_pulse: assert property (dma_ptr_reset |=> !dma_ptr_reset) else $error("rewind too long");
  chk_carrier_event: assert property ($changed(carrier_sense_input_n) |-> ##[1:6] carrier_change)
    else $error("carrier event missing");
  chk_idle_ones: assert property ($rose(rx_idle) |-> rx_link_data) else $error("idle without ones");
  cover property (good_frame);
  cover property (crc_error);
  cover property (dma_ptr_reset);
  cover property (rx_idle);
endmodule
bind hrxb_receiver hrxb_receiver_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.sys_clk, .nrst, .psel, .penable,
  .prdata, .pready, .pslverr, .rx_link_data, .carrier_sense_input_n, .dma_ptr_reset, .good_frame,
  .crc_error, .rx_idle, .carrier_change);

// [tb/hrxb_line_model.sv]
`timescale 1ns/1ps
module hrxb_line_model (
  input wire logic sys_clk,
  output logic     lclk,
  output logic     ldat
);
  int ones = 0;
  initial begin
    lclk = 1'b0;
    ldat = 1'b0;
  end
  // ---------------------------------
  // serial cell: data first, edge mid cell
  // ---------------------------------
  task automatic bitx(input logic b);
    ldat <= b;
    repeat (12) @(posedge sys_clk);
    lclk <= 1'b1;
    repeat (13) @(posedge sys_clk);
    lclk <= 1'b0;
  endtask
  task automatic octet(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      bitx(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 5) begin
        bitx(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic flag();
    for (int i = 0; i < 8; i++) bitx(i != 0 && i != 7);
    ones = 0;
  endtask
  task automatic run(input int n);
    repeat (n) bitx(1'b1);
    ones = 0;
  endtask
  task automatic rel();
    ldat <= ~ldat;
  endtask
endmodule

// [tb/hrxb_receiver_bench.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module hrxb_receiver_bench import hrxb_pkg::*;;
  logic        sys_clk, nrst, psel, penable, pwrite, carrier_sense_input_n, dma_ack, rerr;
  logic        pready, pslverr, dma_req, dma_ptr_reset, good_frame, crc_error, rx_overrun, rx_idle;
  logic        carrier_change, rx_link_clk, rx_link_data, stall = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  dma_data;
  logic [1:0]  dma_tag;
  logic [9:0]  got[$];
  logic [7:0]  q[$];
  logic [15:0] f;
  int          n_mismatch = 0, cmp_count = 0, n_good = 0, n_crc = 0, n_rew = 0, n_car = 0, hold = 0, n_ovr = 0;
  int          g, c, r;
  hrxb_receiver #(.FIFO_DEPTH(4)) uut (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rx_link_clk, .rx_link_data, .carrier_sense_input_n, .dma_ack, .dma_req, .dma_data,
    .dma_tag, .dma_ptr_reset, .good_frame, .crc_error, .rx_overrun, .rx_idle, .carrier_change);
  hrxb_line_model lm (.sys_clk, .lclk(rx_link_clk), .ldat(rx_link_data));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ---------------------------------
  // event counters and dma drain
  // ---------------------------------
  always @(posedge sys_clk) if (nrst) begin
    n_good += good_frame;
    n_crc += crc_error;
    n_rew += dma_ptr_reset;
    n_car += carrier_change;
    n_ovr += rx_overrun;
  end
  always @(posedge sys_clk) begin
    dma_ack <= 1'b0;
    if (hold > 0) hold <= hold - 1;
    else if (dma_req === 1'b1 && !stall) begin
      dma_ack <= 1'b1;
      got.push_back({dma_tag, dma_data});
      hold <= 2;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] fcs(input logic [7:0] b[$]);
    logic [15:0] s = CRC_INIT;
    foreach (b[i]) for (int k = 0; k < 8; k++) s = (s[0] ^ b[i][k]) ? (s >> 1) ^ CRC_POLY : s >> 1;
    return ~s;
  endfunction
  task automatic frame(input logic bad);
    f = fcs(q) ^ {15'h0000, bad};
    got.delete();
    lm.flag();
    foreach (q[i]) lm.octet(q[i]);
    lm.octet(f[7:0]);
    lm.octet(f[15:8]);
    lm.flag();
    lm.rel();
    repeat (60) @(posedge sys_clk);
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    `CHK("ctrl", {24'h00_0000, CTRL_RESET}, rd)
    apb(1'b0, 12'h0f0, 32'h0000_0000);
    `CHK("slverr", 1'b1, rerr)
    `CHK("rdata", 32'h0000_0000, rd)
  endtask
  task automatic t_good();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    q = {8'h1f, 8'hf8, 8'h7c, 8'h3e};
    g = n_good;
    frame(1'b0);
    `CHK("good", g + 1, n_good)
    q.push_back(f[7:0]);
    q.push_back(f[15:8]);
    `CHK("entries", q.size() + 1, got.size())
    foreach (q[i]) `CHK("byte", {TAG_DATA, q[i]}, got[i])
    `CHK("end", {TAG_EOF_OK, 8'h00}, got[q.size()])
  endtask
  task automatic t_crc();
    q = {8'h01, 8'h02, 8'h03};
    g = n_good;
    c = n_crc;
    r = n_rew;
    frame(1'b1);
    `CHK("crc", c + 1, n_crc)
    `CHK("rewind", r + 1, n_rew)
    `CHK("nogood", g, n_good)
    apb(1'b1, ADDR_CTRL, 32'h0000_0009);
    frame(1'b1);
    `CHK("badtag", TAG_EOF_BAD, got[got.size() - 1][9:8])
    apb(1'b0, ADDR_CRCERR, 32'h0000_0000);
    `CHK("crcreg", 32'h0000_0002, rd)
    apb(1'b1, ADDR_CRCERR, 32'h0000_0000);
    apb(1'b0, ADDR_CRCERR, 32'h0000_0000);
    `CHK("crcclr", 32'h0000_0000, rd)
  endtask
  task automatic t_addr();
    logic [7:0] a[5] = '{8'h35, 8'h5a, 8'hff, 8'h77, 8'h5b};
    int p[5] = '{1, 1, 1, 0, 0};
    apb(1'b1, ADDR_CMP, 32'h000f_5a30);
    apb(1'b0, ADDR_CMP, 32'h0000_0000);
    `CHK("cmpreg", 32'h000f_5a30, rd)
    apb(1'b1, ADDR_CTRL, 32'h0000_0007);
    for (int i = 0; i < 5; i++) begin
      q = {a[i], 8'h03, 8'h11};
      g = n_good;
      r = n_rew;
      frame(1'b0);
      `CHK("pass", g + p[i], n_good)
      `CHK("drop", r + 1 - p[i], n_rew)
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0005);
    q = {8'h77, 8'h5a, 8'h11};
    g = n_good;
    frame(1'b0);
    `CHK("second", g + 1, n_good)
  endtask
  task automatic t_abort();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    g = n_good;
    c = n_crc;
    r = n_rew;
    for (int i = 0; i < 2; i++) begin
      lm.flag();
      lm.octet(8'h12);
      lm.octet(8'h34);
      if (i == 0) lm.run(8);
      else lm.flag();
      lm.rel();
      repeat (60) @(posedge sys_clk);
    end
    `CHK("rewinds", r + 2, n_rew)
    `CHK("silent", g, n_good)
    `CHK("nocrc", c, n_crc)
  endtask
  task automatic t_idle();
    lm.run(16);
    repeat (4) @(posedge sys_clk);
    `CHK("idle", 1'b1, rx_idle)
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK("idlebit", 1'b1, rd[3])
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    repeat (4) @(posedge sys_clk);
    `CHK("off", 1'b0, rx_idle)
  endtask
  task automatic t_carrier();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    c = n_car;
    carrier_sense_input_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("cd_fall", c + 1, n_car)
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK("cd_bit", 1'b1, rd[4])
    carrier_sense_input_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK("cd_rise", c + 2, n_car)
  endtask
  task automatic t_residue();
    apb(1'b1, ADDR_CTRL, 32'h0000_0009);
    got.delete();
    q = {8'h11, 8'h22, 8'h33, 8'h44};
    lm.flag();
    foreach (q[i]) lm.octet(q[i]);
    lm.bitx(1'b1);
    lm.bitx(1'b0);
    lm.bitx(1'b1);
    lm.flag();
    lm.rel();
    repeat (60) @(posedge sys_clk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK("residue", 3'h3, rd[2:0])
    `CHK("entries", 5, got.size())
    `CHK("orphans", 8'h05, got[got.size() - 1][7:0])
  endtask
  task automatic t_trans(input logic [31:0] cw);
    g = n_good;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, cw);
    got.delete();
    carrier_sense_input_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    q = {8'ha5, 8'h3c, 8'h69};
    foreach (q[i]) lm.octet(q[i]);
    repeat (60) @(posedge sys_clk);
    carrier_sense_input_n <= 1'b1;
    `CHK("raw_count", 3, got.size())
    foreach (q[i]) `CHK("raw_byte", {TAG_DATA, q[i]}, got[i])
    `CHK("unframed", g, n_good)
  endtask
  task automatic t_bus16();
    r = n_ovr;
    stall <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0021);
    lm.flag();
    lm.octet(8'h12);
    lm.octet(8'h34);
    `CHK("req_one", 1'b0, dma_req)
    lm.octet(8'h56);
    `CHK("req_two", 1'b1, dma_req)
    lm.octet(8'h78);
    lm.octet(8'h9a);
    lm.octet(8'hbc);
    `CHK("overrun", r + 1, n_ovr)
    lm.run(8);
    lm.rel();
    repeat (60) @(posedge sys_clk);
    `CHK("flushed", 1'b0, dma_req)
    stall <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    carrier_sense_input_n = 1'b1;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_good();
    t_crc();
    t_addr();
    t_abort();
    t_idle();
    t_carrier();
    t_residue();
    t_trans(32'h0000_0011);
    t_trans(32'h0000_0051);
    t_bus16();
    tally_and_finish();
  end
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
